// ---- rtl/pe_status_pkg.sv ----
// Package: constants and types for the program/erase status register
// What this block does
// - Bit 7 reads 0 while controller busy, 1 when ready.
// - Status register appears on data lines 7..0 for any read address.
// - Bit 6 set when an erase is paused by suspend awaiting resume.
// - Resume command clears bit 6.
// - Suspend may be ignored if operation finishes; suspend bits valid only when ready.
// - Bit 5 set when maximum erase pulses applied and verify still fails.
// - Bit 5 sticky until clear-status command or hardware reset.
// - Bit 4 set on program, buffered program or unlock code verify failure.
// - Bit 4 sticky until clear-status command or hardware reset.
// - Bit 3 set when program or erase attempted with enable input low.
// - Bit 3 sticky until clear-status command or hardware reset.
// - Bit 2 set when a program is paused by suspend awaiting resume.
// - Resume command clears bit 2.
// - Program or erase on protected block with enable input high is aborted and sets bit 1.
// - Bit 1 sticky until clear-status command or hardware reset.
// - While any error bit is set, new program or erase appears to fail.
// - Bit 0 reads 0 when locked, 1 when unlocked; locked after reset.
// - Variant without password protection reads bit 0 as 1 from the first clock after reset.
`default_nettype none
package pe_status_pkg;
  localparam int STATUS_W = 8;
  localparam int BIT_READY = 7;
  localparam int BIT_ERASE_SUSP = 6;
  localparam int BIT_ERASE_ERR = 5;
  localparam int BIT_PROG_ERR = 4;
  localparam int BIT_ENABLE_LOW = 3;
  localparam int BIT_PROG_SUSP = 2;
  localparam int BIT_PROTECT_VIOL = 1;
  localparam int BIT_UNLOCKED = 0;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  typedef struct packed {
    logic start_program;
    logic start_erase;
    logic suspend;
    logic resume;
    logic clear_status;
    logic lock;
  } command_t;

  typedef struct packed {
    logic done;
    logic paused;
    logic erase_verify_fail;
    logic program_verify_fail;
    logic unlock_ok;
    logic unlock_fail;
  } engine_event_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_PROGRAM,
    OP_ERASE
  } op_t;
endpackage
`default_nettype wire

// ---- rtl/sticky_flag.sv ----
// Sticky flag: set has priority over clear
`default_nettype none
module sticky_flag (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  logic next_flag;
  assign next_flag = set ? 1'b1 : (clear ? 1'b0 : flag);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/flash_program_erase_status_reg.sv ----
// Status register of the flash program/erase controller
`default_nettype none
module flash_program_erase_status_reg #(
  parameter bit HAS_PASSWORD = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pe_status_pkg::command_t cmd,
  input wire logic program_erase_enable_input,
  input wire logic target_protected,
  input wire pe_status_pkg::engine_event_t engine,
  input wire logic status_read,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic engine_start,
  output pe_status_pkg::op_t engine_op,
  output logic engine_suspend,
  output logic engine_resume,
  output logic [7:0] status
);
  ////////////////////////////////////////////////////////////////////////
  // Controller state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_SUSPENDING,
    ST_PAUSED
  } ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;
  pe_status_pkg::op_t op;
  pe_status_pkg::op_t next_op;

  logic erase_err;
  logic prog_err;
  logic enable_low;
  logic protect_viol;
  logic unlocked;
  logic next_unlocked;

  wire any_error = erase_err | prog_err | enable_low | protect_viol;
  wire start_req = (cmd.start_program | cmd.start_erase) && state == ST_IDLE;
  wire start_ok = start_req && program_erase_enable_input && !target_protected && !any_error;
  wire set_enable_low = start_req && !program_erase_enable_input;
  wire set_protect = start_req && program_erase_enable_input && !target_protected ? 1'b0 :
                     start_req && program_erase_enable_input;
  wire running = state == ST_RUN || state == ST_SUSPENDING;
  wire set_erase_err = running && op == pe_status_pkg::OP_ERASE && engine.erase_verify_fail;
  wire set_prog_err = (running && op == pe_status_pkg::OP_PROGRAM && engine.program_verify_fail)
                      || engine.unlock_fail;
  wire resume_req = cmd.resume && state == ST_PAUSED;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    next_op = op;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_RUN;
          next_op = cmd.start_erase ? pe_status_pkg::OP_ERASE : pe_status_pkg::OP_PROGRAM;
        end
      end
      ST_RUN: begin
        if (engine.done) begin
          next_state = ST_IDLE;
          next_op = pe_status_pkg::OP_NONE;
        end else if (cmd.suspend) begin
          next_state = ST_SUSPENDING;
        end
      end
      ST_SUSPENDING: begin
        // Operation may finish before it pauses; suspend is then dropped
        if (engine.done) begin
          next_state = ST_IDLE;
          next_op = pe_status_pkg::OP_NONE;
        end else if (engine.paused) begin
          next_state = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        if (resume_req) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_op = pe_status_pkg::OP_NONE;
      end
    endcase
  end

  assign next_unlocked = !HAS_PASSWORD ? 1'b1 :
                         cmd.lock ? 1'b0 :
                         (engine.unlock_ok ? 1'b1 : unlocked);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= pe_status_pkg::OP_NONE;
      unlocked <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      unlocked <= next_unlocked;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky error flags
  sticky_flag u_erase_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set(set_erase_err),
    .clear(cmd.clear_status),
    .flag(erase_err)
  );
  sticky_flag u_prog_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set(set_prog_err),
    .clear(cmd.clear_status),
    .flag(prog_err)
  );
  sticky_flag u_enable_low (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set(set_enable_low),
    .clear(cmd.clear_status),
    .flag(enable_low)
  );
  sticky_flag u_protect (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set(set_protect),
    .clear(cmd.clear_status),
    .flag(protect_viol)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status assembly, registered from next values
  logic [7:0] next_status;
  always_comb begin
    next_status = 8'h00;
    next_status[pe_status_pkg::BIT_READY] = next_state == ST_IDLE || next_state == ST_PAUSED;
    next_status[pe_status_pkg::BIT_ERASE_SUSP] =
      next_state == ST_PAUSED && next_op == pe_status_pkg::OP_ERASE;
    next_status[pe_status_pkg::BIT_PROG_SUSP] =
      next_state == ST_PAUSED && next_op == pe_status_pkg::OP_PROGRAM;
    next_status[pe_status_pkg::BIT_ERASE_ERR] = set_erase_err | (erase_err & ~cmd.clear_status);
    next_status[pe_status_pkg::BIT_PROG_ERR] = set_prog_err | (prog_err & ~cmd.clear_status);
    next_status[pe_status_pkg::BIT_ENABLE_LOW] = set_enable_low | (enable_low & ~cmd.clear_status);
    next_status[pe_status_pkg::BIT_PROTECT_VIOL] = set_protect | (protect_viol & ~cmd.clear_status);
    next_status[pe_status_pkg::BIT_UNLOCKED] = next_unlocked;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= pe_status_pkg::STATUS_RESET;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      status <= next_status;
      data_out <= next_status;
      data_oe_n <= !status_read;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Engine controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_start <= 1'b0;
      engine_op <= pe_status_pkg::OP_NONE;
      engine_suspend <= 1'b0;
      engine_resume <= 1'b0;
    end else begin
      engine_start <= start_ok;
      engine_op <= next_op;
      engine_suspend <= state == ST_RUN && cmd.suspend && !engine.done;
      engine_resume <= resume_req;
    end
  end
endmodule
`default_nettype wire

// ---- test/pe_status_props.sv ----
// Checker bound to the status register ports
`default_nettype none
module pe_status_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pe_status_pkg::command_t cmd,
  input wire logic program_erase_enable_input,
  input wire logic target_protected,
  input wire pe_status_pkg::engine_event_t engine,
  input wire logic engine_start,
  input wire logic [7:0] status
);
  wire logic idle = status[7:1] == 7'h40;
  wire logic go = cmd.start_program | cmd.start_erase;
  wire logic en = program_erase_enable_input;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_start_busy: assert property (idle && go && en && !target_protected |=> !status[7] && engine_start)
    else $error("start ignored");
  a_enable_low: assert property (idle && go && !en |=> status[7] && status[3]) else $error("no enable flag");
  a_err_blocks: assert property (status[7] && go && |(status & 8'h3A) |=> !engine_start)
    else $error("run despite error");
  a_erase_fail: assert property (!status[7] && engine.erase_verify_fail |=> status[5]) else $error("no erase error");
  a_prog_fail: assert property (engine.unlock_fail || !status[7] && engine.program_verify_fail |=> status[4])
    else $error("no program error");
  a_err_sticky:
    assert property (!cmd.clear_status |=> (8'h3A & ~status & $past(status)) == 8'h00) else $error("error bit lost");
  a_resume_clear: assert property (status[7] && |(status & 8'h44) && cmd.resume |=> (status & 8'hC4) == 8'h00)
    else $error("resume kept suspend");
  a_pause_sets: assert property (!status[7] && engine.paused |=> status[7] && (status[6] ^ status[2]))
    else $error("pause not shown");
  c_paused: cover property (engine.paused);
  c_erase_err: cover property (status[5]);
  c_unlocked: cover property (status[0]);
endmodule
bind flash_program_erase_status_reg pe_status_props i_pe_status_props (.core_clk, .rst_n, .cmd,
  .program_erase_enable_input, .target_protected, .engine, .engine_start, .status);
`default_nettype wire

// ---- test/pe_engine_model.sv ----
// Model of the program/erase algorithm behind the status block
`default_nettype none
module pe_engine_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic engine_start,
  input wire logic engine_suspend,
  input wire logic engine_resume,
  input wire logic fail,
  input wire pe_status_pkg::op_t engine_op,
  output pe_status_pkg::engine_event_t engine
);
  logic [3:0] left;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      {left, engine} <= '0;
    else begin
      left <= engine_start | engine_resume ? 4'h6 : engine_suspend ? 4'h0 : left - {3'h0, left != 4'h0};
      // Suspend arriving after completion is dropped
      engine <= {left == 4'h1, engine_suspend & left != 4'h0, left == 4'h1 & fail & engine_op == pe_status_pkg::OP_ERASE,
        left == 4'h1 & fail & engine_op == pe_status_pkg::OP_PROGRAM, 2'b00};
    end
  end
endmodule
`default_nettype wire

// ---- test/test_flash_program_erase_status_reg.sv ----
// Self-checking bench of the program/erase status register
`default_nettype none
module test_flash_program_erase_status_reg;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, en = 1'b1, prot = 1'b0, fail = 1'b0, rd = 1'b0;
  logic [11:0] req = 12'h000;
  logic [7:0] data_out, status, status_nopw;
  logic oe_n, start, susp, res;
  pe_status_pkg::op_t op;
  pe_status_pkg::engine_event_t evt, engine;
  int bad_count = 0, n_compared = 0, cycles = 0;
  assign engine = evt | req[5:0];
  always #5 core_clk = ~core_clk;
  flash_program_erase_status_reg i_flash_program_erase_status_reg (.core_clk, .rst_n, .cmd(req[11:6]),
    .program_erase_enable_input(en), .target_protected(prot), .engine, .status_read(rd), .data_out,
    .data_oe_n(oe_n), .engine_start(start), .engine_op(op), .engine_suspend(susp), .engine_resume(res), .status);
  pe_engine_model i_pe_engine_model (.core_clk, .rst_n, .engine_start(start), .engine_suspend(susp),
    .engine_resume(res), .fail, .engine_op(op), .engine(evt));
  // Variant without password protection: bit 0 must read 1 once clocked out of reset
  for (genvar g = 0; g < 1; g++) begin : nopw
    flash_program_erase_status_reg #(.HAS_PASSWORD(1'b0)) i_flash_program_erase_status_reg (.core_clk, .rst_n,
      .cmd(req[11:6]), .program_erase_enable_input(en), .target_protected(prot), .engine(req[5:0]),
      .status_read(rd), .data_out(), .data_oe_n(), .engine_start(), .engine_op(), .engine_suspend(),
      .engine_resume(), .status(status_nopw));
  end
  task automatic check(input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Two request cycles (commands and events), then busy and settled status
  task automatic run(input logic [3:0] f, input logic [11:0] a, b, input logic [7:0] busy, done);
    {en, prot, fail, rd} = f;
    req = a;
    @(negedge core_clk);
    req = b;
    @(negedge core_clk);
    req = 12'h000;
    @(negedge core_clk);
    check(status, busy);
    for (int i = 0; i < 40 && status[7] !== 1'b1; i++) @(negedge core_clk);
    check(status, done);
    $display("step done at %0t", $time);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
    if (++cycles == 1000) begin
      bad_count++;
      print_verdict();
    end
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    run(4'h8, 12'h400, 12'h200, 8'h00, 8'hC0);
    run(4'h8, 12'h100, 12'h000, 8'h00, 8'h80);
    run(4'h8, 12'h800, 12'h200, 8'h00, 8'h84);
    run(4'h8, 12'h100, 12'h000, 8'h00, 8'h80);
    run(4'hA, 12'h400, 12'h000, 8'h00, 8'hA0);
    run(4'hA, 12'h080, 12'h800, 8'h00, 8'h90);
    run(4'h0, 12'h080, 12'h800, 8'h88, 8'h88);
    run(4'h8, 12'h400, 12'h000, 8'h88, 8'h88);
    run(4'hC, 12'h080, 12'h400, 8'h82, 8'h82);
    run(4'h8, 12'h080, 12'h002, 8'h81, 8'h81);
    run(4'h9, 12'h040, 12'h001, 8'h90, 8'h90);
    check(data_out, 8'h90);
    check({7'h00, oe_n}, 8'h00);
    check({7'h00, status_nopw[0]}, 8'h01);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    run(4'h8, 12'h000, 12'h000, 8'h80, 8'h80);
    check(status_nopw, 8'h81);
    print_verdict();
  end
endmodule
`default_nettype wire
